// file: src/tcm_params.svh
// constants of the tandem connection defect monitor: offsets, fields, resets, timing
// assumes inclusion by the monitor module only
`ifndef TCM_PARAMS_SVH
`define TCM_PARAMS_SVH

// ***********************************************
// register byte addresses; trace banks by upper address nibble
// ***********************************************
`define TCM_ADDR_CTRL        8'h00
`define TCM_ADDR_DEGCFG      8'h04
`define TCM_ADDR_STATUS      8'h08
`define TCM_ADDR_SECFLAGS    8'h0C
`define TCM_ADDR_NEAR_EBC    8'h10
`define TCM_ADDR_FAR_EBC     8'h14
`define TCM_ADDR_OUTFAR_EBC  8'h18
`define TCM_ADDR_EXP_TRACE   4'h2
`define TCM_ADDR_ACC_TRACE   4'h3

// ***********************************************
// control fields and reset values
// ***********************************************
`define TCM_CTRL_SSF_REP     0
`define TCM_CTRL_RDI_REP     1
`define TCM_CTRL_ODI_REP     2
`define TCM_CTRL_TRACE_DIS   3
`define TCM_CTRL_TP_LO       4
`define TCM_CTRL_RESET       6'h10
`define TCM_TP_MONITOR       2'h1
`define TCM_DEG_THR_RESET    16'h0010
`define TCM_DEG_SEC_RESET    4'h7

// ***********************************************
// overhead byte layout and framing
// ***********************************************
`define TCM_MF_PATTERN       12'hFFE
`define TCM_MF_LAST          7'h4B
`define TCM_MF_FAS_END       7'h05
`define TCM_MF_RELOCK        7'h06
`define TCM_MF_TRACE_FIRST   7'h08
`define TCM_MF_TRACE_LAST    7'h47
`define TCM_MF_RDI           7'h48
`define TCM_MF_ODI           7'h49
`define TCM_PERSIST_LAST     3'h4
`define TCM_TRACE_ACCEPT     2'h2

// ***********************************************
// timing
// ***********************************************
`define TCM_SECOND_NS        1000000000
`define TCM_CLK_PERIOD_NS    10

`endif

// file: src/tcm_pkg.sv
// types of the tandem connection defect monitor
// assumes nothing beyond the compile order
package tcm_pkg;
  typedef enum logic [0:0] {
    MF_LOST   = 1'b0,
    MF_LOCKED = 1'b1
  } tcm_align_type;
endpackage

// file: src/tcm_defect_mon.sv
// defect detection, correlation and one-second monitoring of a tandem connection
// assumes frame inputs synchronous to clk, one frameStart pulse per 125 us frame
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "tcm_params.svh"

// Summary of operation
// R1 - five all-zero overhead frames set unequipped
// R2 - five nonzero overhead frames clear unequipped
// R3 - tandem loss follows multiframe lost state
// R4 - trace mismatch found and cleared within 1s
// R5 - server fail suppresses trace mismatch
// R6 - software can disable trace mismatch detection
// R7 - parity violations drive error rate poor
// R8 - recovered remote bit drives remote defect
// R9 - recovered outgoing bit drives outgoing defect
// R10 - trail fail and degraded derived from defects
// R11 - unequipped cause; tandem loss cause unless unequipped
// R12 - trace cause only without unequipped, loss
// R13 - degrade cause only without trace, loss
// R14 - server fail cause gated, option default off
// R15 - remote cause gated by option and defects
// R16 - remote cause report option defaults off
// R17 - outgoing cause report option defaults off
// R18 - per-second defect seconds and block sums
// R19 - search alignment word, keep checking it
// R20 - two bad words lose, one good regains
// R21 - remote bit one means remote defect
// R22 - parity count mismatch counts near block
// R23 - causes forced off unless monitoring mode
// R24 - second strobe snapshots then clears counters
module tcm_defect_mon #(
  parameter int ONE_SEC_CYCLES = `TCM_SECOND_NS / `TCM_CLK_PERIOD_NS,
  parameter int CNT_W          = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             frameStart,
  input  wire logic [7:0]       tandemOverheadByte,
  input  wire logic [3:0]       localParityErrors,
  input  wire logic             serverSignalFailIn,
  input  wire logic             hardwareFaultFlag,
  output logic                  trailSignalFail,
  output logic                  trailSignalDegraded,
  output logic [6:0]            faultCauses,
  output logic                  secondStrobe
);

  localparam int SEC_W = $clog2(ONE_SEC_CYCLES);

  // ***********************************************
  // shared arithmetic
  // ***********************************************
  // five-frame persistence: state flips after five observations against it
  function automatic logic [3:0] tcm_persist(input logic [2:0] cnt, input logic st,
                                             input logic hit);
    if (hit == st) begin
      return {st, 3'h0};
    end else if (cnt == `TCM_PERSIST_LAST) begin
      return {~st, 3'h0};
    end else begin
      return {st, 3'(cnt + 3'h1)};
    end
  endfunction

  // saturating so a stuck fault never wraps a count back to small values
  function automatic logic [CNT_W-1:0] tcm_inc(input logic [CNT_W-1:0] cnt, input logic en);
    if (en && (cnt != {CNT_W{1'b1}})) begin
      return CNT_W'(cnt + 1'b1);
    end else begin
      return cnt;
    end
  endfunction

  // ***********************************************
  // registers and state
  // ***********************************************
  logic [5:0]               ctrl_r;
  logic [15:0]              degThr_r;
  logic [3:0]               degSec_r;
  logic [31:0]              expTrace_r [4];
  logic [127:0]             accTrace_r;
  logic [127:0]             lastTrace_r;
  logic [125:0]             traceShift_r;
  logic [1:0]               traceStable_r;
  logic [9:0]               fasShift_r;
  logic [6:0]               mfCnt_r;
  logic                     fasErrRun_r;
  tcm_pkg::tcm_align_type   alignState_r;
  logic                     unequipped_r;
  logic [2:0]               uneqCnt_r;
  logic                     remote_r;
  logic [2:0]               remoteCnt_r;
  logic                     outgoing_r;
  logic [2:0]               outgoingCnt_r;
  logic                     errorRatePoor_r;
  logic [3:0]               degRun_r;
  logic [SEC_W-1:0]         secCnt_r;
  logic [2:0]               secFlags_r;
  logic [2:0]               secFlagsSnap_r;
  logic [CNT_W-1:0]         nearEbc_r;
  logic [CNT_W-1:0]         farEbc_r;
  logic [CNT_W-1:0]         outFarEbc_r;
  logic [CNT_W-1:0]         nearEbcSnap_r;
  logic [CNT_W-1:0]         farEbcSnap_r;
  logic [CNT_W-1:0]         outFarEbcSnap_r;
  logic                     trailSignalFail_r;
  logic                     trailSignalDegraded_r;
  logic [6:0]               faultCauses_r;
  logic [31:0]              prdata_r;

  // ***********************************************
  // combinational decode
  // ***********************************************
  wire         apbSetup   = psel && !penable;
  wire         apbWrite   = psel && penable && pwrite;
  wire         isCtrl     = (paddr == `TCM_ADDR_CTRL);
  wire         isDegCfg   = (paddr == `TCM_ADDR_DEGCFG);
  wire         isStatus   = (paddr == `TCM_ADDR_STATUS);
  wire         isSecFlags = (paddr == `TCM_ADDR_SECFLAGS);
  wire         isNearEbc  = (paddr == `TCM_ADDR_NEAR_EBC);
  wire         isFarEbc   = (paddr == `TCM_ADDR_FAR_EBC);
  wire         isOutEbc   = (paddr == `TCM_ADDR_OUTFAR_EBC);
  wire         isExpTrace = (paddr[7:4] == `TCM_ADDR_EXP_TRACE) && (paddr[1:0] == 2'h0);
  wire         isAccTrace = (paddr[7:4] == `TCM_ADDR_ACC_TRACE) && (paddr[1:0] == 2'h0);
  wire         mapped     = isCtrl || isDegCfg || isStatus || isSecFlags || isNearEbc ||
                            isFarEbc || isOutEbc || isExpTrace || isAccTrace;
  wire [1:0]   traceIdx   = paddr[3:2];

  wire         supervisionOn   = (ctrl_r[`TCM_CTRL_TP_LO +: 2] == `TCM_TP_MONITOR);
  wire [1:0]   mfBits          = tandemOverheadByte[1:0];
  wire [11:0]  alignmentWord   = {fasShift_r, mfBits};
  wire         alignmentWordOk = (alignmentWord == `TCM_MF_PATTERN);
  wire         multiframeLocked = (alignState_r == tcm_pkg::MF_LOCKED);
  wire         tandemLoss      = (alignState_r == tcm_pkg::MF_LOST);
  wire [127:0] expTrace        = {expTrace_r[3], expTrace_r[2], expTrace_r[1], expTrace_r[0]};
  wire [127:0] newTrace        = {traceShift_r, mfBits};
  wire         traceTick       = frameStart && multiframeLocked &&
                                 (mfCnt_r == `TCM_MF_TRACE_LAST);
  wire         traceInWindow   = (mfCnt_r >= `TCM_MF_TRACE_FIRST) &&
                                 (mfCnt_r <= `TCM_MF_TRACE_LAST);
  // R4 R5 R6 - trace mismatch gating
  wire         traceMismatch   = (accTrace_r != expTrace) && !serverSignalFailIn &&
                                 !ctrl_r[`TCM_CTRL_TRACE_DIS];
  // R22 - near block by count difference
  wire         nearBlk = frameStart && (localParityErrors != tandemOverheadByte[7:4]);
  wire         farBlk  = frameStart && tandemOverheadByte[3];
  wire         outBlk  = frameStart && tandemOverheadByte[2];
  wire         secTick = (secCnt_r == SEC_W'(ONE_SEC_CYCLES - 1));

  // R10 - trail fail and degraded
  wire         tsfNxt  = serverSignalFailIn || unequipped_r || traceMismatch || tandemLoss;
  wire         tsdNxt  = errorRatePoor_r;

  // R11 R12 R13 R14 R15 R17 R23 - correlation under supervision
  wire [6:0]   causesNxt = {7{supervisionOn}} & {
    outgoing_r && ctrl_r[`TCM_CTRL_ODI_REP],
    remote_r && ctrl_r[`TCM_CTRL_RDI_REP] && !unequipped_r && !traceMismatch && !tandemLoss,
    serverSignalFailIn && ctrl_r[`TCM_CTRL_SSF_REP],
    errorRatePoor_r && !traceMismatch && !tandemLoss,
    traceMismatch && !unequipped_r && !tandemLoss,
    tandemLoss && !unequipped_r,
    unequipped_r};

  wire [3:0]       uneqNxt    = tcm_persist(uneqCnt_r, unequipped_r, tandemOverheadByte == 8'h00);
  wire [3:0]       remoteNxt  = tcm_persist(remoteCnt_r, remote_r, tandemOverheadByte[0]);
  wire [3:0]       outNxt     = tcm_persist(outgoingCnt_r, outgoing_r, tandemOverheadByte[1]);
  wire [CNT_W-1:0] nearEbc_nxt  = tcm_inc(nearEbc_r, nearBlk);
  wire [CNT_W-1:0] farEbc_nxt   = tcm_inc(farEbc_r, farBlk);
  wire [CNT_W-1:0] outEbc_nxt   = tcm_inc(outFarEbc_r, outBlk);
  wire [2:0]       secFlags_nxt = secFlags_r |
                                  {outgoing_r, remote_r, trailSignalFail_r || hardwareFaultFlag};
  wire             badSecond    = ({{(32-CNT_W){1'b0}}, nearEbc_nxt} >= {16'h0000, degThr_r});

  wire [31:0] statusWord = {9'h000, faultCauses_r, 6'h00, hardwareFaultFlag,
                            trailSignalDegraded_r, trailSignalFail_r, serverSignalFailIn,
                            outgoing_r, remote_r, errorRatePoor_r, traceMismatch,
                            tandemLoss, unequipped_r};
  wire [31:0] readMux =
      isCtrl     ? {26'h0000000, ctrl_r} :
      isDegCfg   ? {12'h000, degSec_r, degThr_r} :
      isStatus   ? statusWord :
      isSecFlags ? {29'h00000000, secFlagsSnap_r} :
      isNearEbc  ? 32'(nearEbcSnap_r) :
      isFarEbc   ? 32'(farEbcSnap_r) :
      isOutEbc   ? 32'(outFarEbcSnap_r) :
      isExpTrace ? expTrace_r[traceIdx] :
      isAccTrace ? accTrace_r[32*traceIdx +: 32] : 32'h00000000;

  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !mapped;
  assign prdata              = prdata_r;
  assign trailSignalFail     = trailSignalFail_r;
  assign trailSignalDegraded = trailSignalDegraded_r;
  assign faultCauses         = faultCauses_r;
  assign secondStrobe        = secTick;

  // ***********************************************
  // register file
  // ***********************************************
  // R14 R16 R17 - report options reset to off
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r   <= `TCM_CTRL_RESET;
      degThr_r <= `TCM_DEG_THR_RESET;
      degSec_r <= `TCM_DEG_SEC_RESET;
      prdata_r <= 32'h00000000;
      for (int i = 0; i < 4; i++) begin
        expTrace_r[i] <= 32'h00000000;
      end
    end else begin
      if (apbSetup) begin
        prdata_r <= readMux;
      end
      if (apbWrite && isCtrl) begin
        ctrl_r <= pwdata[5:0];
      end
      if (apbWrite && isDegCfg) begin
        degThr_r <= pwdata[15:0];
        degSec_r <= pwdata[19:16];
      end
      if (apbWrite && isExpTrace) begin
        expTrace_r[traceIdx] <= pwdata;
      end
    end
  end

  // ***********************************************
  // multiframe alignment and trace capture
  // ***********************************************
  // R3 R19 R20 - search, check and loss of multiframe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alignState_r <= tcm_pkg::MF_LOST;
      fasShift_r   <= 10'h000;
      mfCnt_r      <= 7'h00;
      fasErrRun_r  <= 1'b0;
    end else if (frameStart) begin
      fasShift_r <= alignmentWord[9:0];
      mfCnt_r    <= (mfCnt_r == `TCM_MF_LAST) ? 7'h00 : 7'(mfCnt_r + 7'h01);
      unique case (alignState_r)
        tcm_pkg::MF_LOST: begin
          if (alignmentWordOk) begin
            alignState_r <= tcm_pkg::MF_LOCKED;
            mfCnt_r      <= `TCM_MF_RELOCK;
            fasErrRun_r  <= 1'b0;
          end
        end
        tcm_pkg::MF_LOCKED: begin
          if (mfCnt_r == `TCM_MF_FAS_END) begin
            fasErrRun_r <= !alignmentWordOk;
            if (!alignmentWordOk && fasErrRun_r) begin
              alignState_r <= tcm_pkg::MF_LOST;
            end
          end
        end
      endcase
    end
  end

  // R4 - trace accepted on the fourth equal multiframe in a row, well inside a second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      traceShift_r  <= '0;
      lastTrace_r   <= '0;
      accTrace_r    <= '0;
      traceStable_r <= 2'h0;
    end else begin
      if (frameStart && multiframeLocked && traceInWindow) begin
        traceShift_r <= newTrace[125:0];
      end
      if (traceTick) begin
        lastTrace_r <= newTrace;
        if (newTrace != lastTrace_r) begin
          traceStable_r <= 2'h0;
        end else if (traceStable_r == `TCM_TRACE_ACCEPT) begin
          accTrace_r <= newTrace;
        end else begin
          traceStable_r <= 2'(traceStable_r + 2'h1);
        end
      end
    end
  end

  // ***********************************************
  // persistence filters
  // ***********************************************
  // R1 R2 - unequipped per frame; R8 R9 R21 - remote bits per multiframe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {unequipped_r, uneqCnt_r}  <= 4'h0;
      {remote_r, remoteCnt_r}    <= 4'h0;
      {outgoing_r, outgoingCnt_r} <= 4'h0;
    end else if (frameStart) begin
      {unequipped_r, uneqCnt_r} <= uneqNxt;
      if (multiframeLocked && (mfCnt_r == `TCM_MF_RDI)) begin
        {remote_r, remoteCnt_r} <= remoteNxt;
      end
      if (multiframeLocked && (mfCnt_r == `TCM_MF_ODI)) begin
        {outgoing_r, outgoingCnt_r} <= outNxt;
      end
    end
  end

  // R7 - degraded after a run of bad seconds, cleared after as many good
  always_ff @(posedge clk) begin
    if (!resetn) begin
      errorRatePoor_r <= 1'b0;
      degRun_r        <= 4'h0;
    end else if (secTick) begin
      if (badSecond == errorRatePoor_r) begin
        degRun_r <= 4'h0;
      end else if (degRun_r >= 4'(degSec_r - 4'h1)) begin
        errorRatePoor_r <= badSecond;
        degRun_r        <= 4'h0;
      end else begin
        degRun_r <= 4'(degRun_r + 4'h1);
      end
    end
  end

  // ***********************************************
  // outputs and one-second monitoring
  // ***********************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trailSignalFail_r     <= 1'b0;
      trailSignalDegraded_r <= 1'b0;
      faultCauses_r         <= 7'h00;
    end else begin
      trailSignalFail_r     <= tsfNxt;
      trailSignalDegraded_r <= tsdNxt;
      faultCauses_r         <= causesNxt;
    end
  end

  // R18 R24 - events in the strobe cycle land in the closing period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      secCnt_r        <= '0;
      secFlags_r      <= 3'h0;
      secFlagsSnap_r  <= 3'h0;
      nearEbc_r       <= '0;
      farEbc_r        <= '0;
      outFarEbc_r     <= '0;
      nearEbcSnap_r   <= '0;
      farEbcSnap_r    <= '0;
      outFarEbcSnap_r <= '0;
    end else if (secTick) begin
      secCnt_r        <= '0;
      secFlagsSnap_r  <= secFlags_nxt;
      nearEbcSnap_r   <= nearEbc_nxt;
      farEbcSnap_r    <= farEbc_nxt;
      outFarEbcSnap_r <= outEbc_nxt;
      secFlags_r      <= 3'h0;
      nearEbc_r       <= '0;
      farEbc_r        <= '0;
      outFarEbc_r     <= '0;
    end else begin
      secCnt_r    <= SEC_W'(secCnt_r + 1'b1);
      secFlags_r  <= secFlags_nxt;
      nearEbc_r   <= nearEbc_nxt;
      farEbc_r    <= farEbc_nxt;
      outFarEbc_r <= outEbc_nxt;
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_bad_word;
    frameStart && multiframeLocked && (mfCnt_r == `TCM_MF_FAS_END) && !alignmentWordOk;
  endsequence
  sequence s_zero_frame;
    frameStart && (tandemOverheadByte == 8'h00);
  endsequence

  property p_uneq_set;
    $rose(unequipped_r) |-> $past(uneqCnt_r) == `TCM_PERSIST_LAST &&
                            $past(frameStart && tandemOverheadByte == 8'h00);
  endproperty
  a_uneq_set: assert property (p_uneq_set) else $error("unequipped set early"); // R1
  property p_uneq_fwd;
    s_zero_frame ##0 (uneqCnt_r == `TCM_PERSIST_LAST) |=> unequipped_r;
  endproperty
  a_uneq_fwd: assert property (p_uneq_fwd) else $error("unequipped not set"); // R1
  property p_uneq_clr;
    $fell(unequipped_r) |-> $past(frameStart && tandemOverheadByte != 8'h00);
  endproperty
  a_uneq_clr: assert property (p_uneq_clr) else $error("unequipped cleared wrongly"); // R2
  property p_mf_lose;
    s_bad_word and fasErrRun_r |=> tandemLoss;
  endproperty
  a_mf_lose: assert property (p_mf_lose) else $error("alignment not lost"); // R20
  property p_mf_find;
    frameStart && tandemLoss && alignmentWordOk |=> multiframeLocked && mfCnt_r == 7'h06;
  endproperty
  a_mf_find: assert property (p_mf_find) else $error("alignment not found"); // R19
  property p_tsf;
    resetn && (serverSignalFailIn || unequipped_r || traceMismatch || tandemLoss)
      |=> trailSignalFail;
  endproperty
  a_tsf: assert property (p_tsf) else $error("trail fail missing"); // R10
  property p_tim_sup;
    serverSignalFailIn |=> !faultCauses[2];
  endproperty
  a_tim_sup: assert property (p_tim_sup) else $error("trace mismatch not suppressed"); // R5
  property p_tim_cause;
    faultCauses[2] |-> $past(!unequipped_r && !tandemLoss && supervisionOn);
  endproperty
  a_tim_cause: assert property (p_tim_cause) else $error("trace cause misgated"); // R12
  property p_ssf_cause;
    faultCauses[4] |-> $past(serverSignalFailIn && ctrl_r[0] && supervisionOn);
  endproperty
  a_ssf_cause: assert property (p_ssf_cause) else $error("server cause misgated"); // R14
  property p_rdi_cause;
    faultCauses[5] |-> $past(remote_r && ctrl_r[1] && !tandemLoss && !unequipped_r);
  endproperty
  a_rdi_cause: assert property (p_rdi_cause) else $error("remote cause misgated"); // R15
  property p_sec_clear;
    secTick |=> nearEbc_r == '0 && nearEbcSnap_r == $past(nearEbc_nxt);
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("second not snapshotted"); // R24
  property p_unmon;
    !supervisionOn |=> faultCauses == 7'h00;
  endproperty
  a_unmon: assert property (p_unmon) else $error("cause outside monitoring"); // R23

endmodule

// file: bench/tcm_frame_src.sv
// upstream tandem source model: framed overhead bytes and local parity counts
// assumes the monitor shares clk and samples byte and count with frameStart
`timescale 1ns/1ps
module tcm_frame_src #(
  parameter int GAP = 16
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       sendZero,
  input  wire logic       traceOne,
  input  wire logic       remoteOn,
  input  wire logic       parityBad,
  output logic            frameStart,
  output logic [7:0]      tandemOverheadByte,
  output logic [3:0]      localParityErrors
);
  // ******************
  // multiframe builder
  // ******************
  localparam logic [11:0] ALIGN = 12'hFFE;
  logic [6:0] mfIdx_r;
  logic [7:0] gap_r;
  logic [1:0] mfBits;
  logic [7:0] frameByte;

  always_comb begin
    mfBits = 2'h0;
    if (mfIdx_r < 7'h06) begin
      mfBits = ALIGN[11 - 2 * mfIdx_r -: 2];
    end else if (mfIdx_r >= 7'h08 && mfIdx_r <= 7'h47) begin
      mfBits = {2{traceOne}};
    end else if (mfIdx_r == 7'h48) begin
      mfBits = {1'b0, remoteOn};
    end else if (mfIdx_r == 7'h49) begin
      mfBits = {remoteOn, 1'b0};
    end
  end

  // incoming error count 1, far and outgoing error bits follow remoteOn
  assign frameByte = sendZero ? 8'h00 : {4'h1, remoteOn, remoteOn, mfBits};
  // idle line shows the inverse so a stale byte never passes for a valid one
  assign tandemOverheadByte = frameStart ? frameByte : ~frameByte;
  assign localParityErrors = parityBad ? 4'h0 : 4'h1;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gap_r <= 8'h00;
      mfIdx_r <= 7'h00;
      frameStart <= 1'b0;
    end else begin
      frameStart <= (gap_r == 8'(GAP - 1));
      gap_r <= (gap_r == 8'(GAP - 1)) ? 8'h00 : gap_r + 8'h01;
      if (frameStart) begin
        mfIdx_r <= (mfIdx_r == 7'h4B) ? 7'h00 : mfIdx_r + 7'h01;
      end
    end
  end
endmodule

// file: bench/testbench.sv
// self-checking bench: APB register tasks plus the framed tandem source model
// assumes a 2000-cycle second and a frame every 16 cycles
`timescale 1ns/1ps
module testbench;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, ohByte;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  parityCnt;
  logic [6:0]  causes;
  logic        frameStart, ssfIn, hwFault, tsf, tsd, strobe;
  logic        sendZero, traceOne, remoteOn, parityBad;
  int          nMismatch, checkCount;

  tcm_defect_mon #(.ONE_SEC_CYCLES(2000), .CNT_W(16)) tcm_defect_mon_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frameStart(frameStart), .tandemOverheadByte(ohByte), .localParityErrors(parityCnt),
    .serverSignalFailIn(ssfIn), .hardwareFaultFlag(hwFault), .trailSignalFail(tsf),
    .trailSignalDegraded(tsd), .faultCauses(causes), .secondStrobe(strobe));
  tcm_frame_src #(.GAP(16)) tcm_frame_src_i (
    .clk(clk), .resetn(resetn), .sendZero(sendZero), .traceOne(traceOne),
    .remoteOn(remoteOn), .parityBad(parityBad), .frameStart(frameStart),
    .tandemOverheadByte(ohByte), .localParityErrors(parityCnt));

  // *************
  // shared tasks
  // *************
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic giveUp;
    nMismatch++;
    $display("[ERR] %0t wait ran out", $time);
    printVerdict();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) giveUp();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
    check({31'h0, err}, {31'h0, a > 8'h3C});
  endtask

  // two edges: causes settle one edge after their defect or option
  task automatic outChk(input logic [8:0] e);
    repeat (2) @(negedge clk);
    check({23'h0, tsd, tsf, causes}, {23'h0, e});
  endtask

  task automatic waitFor(input logic sec, input int cnt);
    int k;
    repeat (cnt) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while ((sec ? strobe : frameStart) !== 1'b1 && k < 3000);
      if (k >= 3000) giveUp();
    end
  endtask

  initial clk = 1'b0;
  always #5 clk = ~clk;

  initial begin
    repeat (80000) @(posedge clk);
    giveUp();
  end

  // ***********
  // scenarios
  // ***********
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ssfIn = 1'b0;
    hwFault = 1'b0;
    sendZero = 1'b0;
    traceOne = 1'b0;
    remoteOn = 1'b0;
    parityBad = 1'b0;
    nMismatch = 0;
    checkCount = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdChk(8'h00, 32'hFFFFFFFF, 32'h10);
    rdChk(8'h04, 32'hFFFFFFFF, 32'h70010);
    rdChk(8'h40, 32'hFFFFFFFF, 32'h0);
    rdChk(8'h08, 32'h2, 32'h2);
    outChk(9'h082);
    waitFor(1'b0, 152);
    rdChk(8'h08, 32'h2, 32'h0);
    outChk(9'h000);
    @(posedge clk);
    traceOne <= 1'b1;
    waitFor(1'b0, 304);
    rdChk(8'h30, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rdChk(8'h08, 32'h4, 32'h4);
    outChk(9'h084);
    @(posedge clk);
    ssfIn <= 1'b1;
    waitFor(1'b0, 2);
    rdChk(8'h08, 32'h44, 32'h40);
    outChk(9'h080);
    apb(1'b1, 8'h00, 32'h11);
    outChk(9'h090);
    @(posedge clk);
    ssfIn <= 1'b0;
    apb(1'b1, 8'h00, 32'h18);
    waitFor(1'b0, 2);
    rdChk(8'h08, 32'h4, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(32 + 4 * i), 32'hFFFFFFFF);
    apb(1'b1, 8'h00, 32'h10);
    waitFor(1'b0, 76);
    rdChk(8'h08, 32'h4, 32'h0);
    @(posedge clk);
    remoteOn <= 1'b1;
    waitFor(1'b0, 456);
    rdChk(8'h08, 32'h30, 32'h30);
    outChk(9'h000);
    apb(1'b1, 8'h00, 32'h16);
    outChk(9'h060);
    waitFor(1'b1, 1);
    rdChk(8'h0C, 32'h6, 32'h6);
    rdChk(8'h14, 32'hFFFF, 32'h7D);
    rdChk(8'h18, 32'hFFFF, 32'h7D);
    @(posedge clk);
    remoteOn <= 1'b0;
    waitFor(1'b0, 1);
    @(posedge clk);
    sendZero <= 1'b1;
    waitFor(1'b0, 4);
    rdChk(8'h08, 32'h1, 32'h0);
    waitFor(1'b0, 1);
    rdChk(8'h08, 32'h1, 32'h1);
    waitFor(1'b0, 152);
    rdChk(8'h08, 32'h2, 32'h2);
    outChk(9'h0C1);
    @(posedge clk);
    sendZero <= 1'b0;
    waitFor(1'b0, 4);
    rdChk(8'h08, 32'h1, 32'h1);
    waitFor(1'b0, 1);
    rdChk(8'h08, 32'h1, 32'h0);
    waitFor(1'b0, 152);
    outChk(9'h060);
    apb(1'b1, 8'h00, 32'h2);
    outChk(9'h000);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h04, 32'h10002);
    waitFor(1'b1, 1);
    @(posedge clk);
    parityBad <= 1'b1;
    hwFault <= 1'b1;
    waitFor(1'b0, 3);
    @(posedge clk);
    parityBad <= 1'b0;
    hwFault <= 1'b0;
    waitFor(1'b1, 1);
    rdChk(8'h10, 32'hFFFF, 32'h3);
    rdChk(8'h0C, 32'h1, 32'h1);
    rdChk(8'h08, 32'h8, 32'h8);
    outChk(9'h108);
    waitFor(1'b1, 1);
    rdChk(8'h10, 32'hFFFF, 32'h0);
    rdChk(8'h0C, 32'h1, 32'h0);
    outChk(9'h000);
    printVerdict();
  end
endmodule
